/* File: hw/ioc_osc_ctrl.sv */
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ns
// Contract
// - 16 MHz HF source via postscaler select
// - HF/MF enabled by select and config/scs
// - HF ready flag while HF runs
// - HF locked flag within 2 percent
// - HF stable flag within half percent
// - Fast start-up oscillator until HF ready
// - 500 kHz MF source, nine derived frequencies
// - MF ready flag while MF runs
// - One trim value shifts HF and MF
// - Trim is 6-bit signed, resets zero
// - Trim moves gradually, no done flag
// - Trim never touches LF source
// - Uncalibrated 31 kHz LF source, feeds timers
// - LF enabled by select 0000 with config/scs, or users
// - LF ready flag while LF runs
// - Two-speed wake counts 1024 external cycles
// - Wait internal fall, set flag, switch
// - External-running flag readable by software
module ioc_osc_ctrl
  import ioc_pkg::*;
#(
  parameter int OST_COUNT = OST_CYCLES
) (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                clk_en,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic                hready,
  input  wire logic [31:0]         hwdata,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic                     irq,
  // Configuration and system inputs
  input  wire logic [2:0]          config_osc_select,
  input  wire logic                lf_users_active,
  input  wire logic                two_speed_enable,
  input  wire logic                wake_start,
  // Analog oscillator status, asynchronous to hclk
  input  wire logic                hf_running_raw,
  input  wire logic                hf_within_lock_raw,
  input  wire logic                hf_within_stable_raw,
  input  wire logic                mf_running_raw,
  input  wire logic                lf_running_raw,
  // Clock levels, sampled as synchronous
  input  wire logic                int_osc_level,
  input  wire logic                ext_osc_level,
  // Oscillator and clock tree controls
  output logic                     high_freq_internal_osc_en,
  output logic                     medium_freq_internal_osc_en,
  output logic                     low_freq_internal_osc_en,
  output logic      [TRIM_W-1:0]   osc_trim_value,
  output ioc_postscale_t           postscale_sel,
  output logic                     fast_startup_sel,
  output logic                     sys_clk_hold,
  output logic                     sys_clk_ext_sel,
  output logic                     osc_startup_timer_active
);

  typedef enum logic [2:0] {
    TS_INTERNAL,
    TS_OST_COUNT,
    TS_WAIT_INT_FALL,
    TS_WAIT_EXT_FALL,
    TS_EXTERNAL
  } ioc_ts_state_t;

  localparam int NUM_RAW = 5;

  // Frequency select decode, shared by the enables and the mux
  function automatic ioc_postscale_t ioc_decode(input logic [3:0] ifs);
    ioc_postscale_t d;
    d.src       = IOC_SRC_LF;
    d.div_shift = 4'h0;
    if (ifs == IFS_LF_CODE) begin
      d.src       = IOC_SRC_LF;
      d.div_shift = 4'h0;
    end else if (ifs <= IFS_MF_LAST) begin
      d.src       = IOC_SRC_MF;
      d.div_shift = IFS_MF_LAST - ifs;
    end else begin
      d.src       = IOC_SRC_HF;
      d.div_shift = IFS_HF_LAST - ifs;
    end
    return d;
  endfunction

  ioc_ctrl_t                ctrl_ff;
  logic signed [TRIM_W-1:0] trim_target_ff;
  logic signed [TRIM_W-1:0] trim_applied_ff;
  logic        [7:0]        trim_step_cnt_ff;
  logic        [5:0]        int_stat_ff;
  logic        [5:0]        int_mask_ff;
  logic        [NUM_RAW-1:0] sync1_ff;
  logic        [NUM_RAW-1:0] sync2_ff;
  logic        [NUM_RAW-1:0] raw_in;
  ioc_flags_t               flags;
  logic        [5:0]        flags_prev_ff;
  logic        [5:0]        flag_rise;
  logic                     ext_running_ff;
  ioc_ts_state_t            ts_state_ff;
  logic        [OST_W-1:0]  ost_cnt_ff;
  logic                     por_pending_ff;
  logic                     int_prev_ff;
  logic                     ext_prev_ff;
  logic                     int_fall;
  logic                     ext_fall;
  logic                     ext_rise;
  logic                     fast_sel_ff;
  ioc_postscale_t           post_ff;
  ioc_postscale_t           dec;
  logic                     hfmf_en;
  logic                     lf_en;
  logic        [31:0]       hrdata_ff;
  logic                     wr_pend_ff;
  logic        [7:0]        wr_addr_ff;
  logic                     addr_ok;
  logic                     rd_take;
  logic                     wr_take;
  logic        [31:0]       rd_value;
  logic        [5:0]        w1c_clear;

  // Bus: zero wait states; a frozen block holds the bus off
  assign hreadyout = clk_en;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;
  assign addr_ok   = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign rd_take   = addr_ok && !hwrite;
  assign wr_take   = addr_ok && hwrite;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else if (clk_en) begin
      wr_pend_ff <= wr_take;
      wr_addr_ff <= haddr[HADDR_W-1:0];
    end
  end

  always_comb begin
    rd_value = 32'h0000_0000;
    case (haddr[HADDR_W-1:0])
      OFF_CTRL:     rd_value = {26'h0, ctrl_ff};
      OFF_TRIM:     rd_value = {26'h0, trim_target_ff};
      OFF_STATUS:   rd_value = {26'h0, flags};
      OFF_INT_STAT: rd_value = {26'h0, int_stat_ff};
      OFF_INT_MASK: rd_value = {26'h0, int_mask_ff};
      default:      rd_value = 32'h0000_0000;
    endcase
  end

  // Read data captured at the address phase; stands for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (clk_en && rd_take) begin
      hrdata_ff <= rd_value;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= '{system_clock_source_select: SCS_RESET, ifs: IFS_RESET};
    end else if (clk_en && wr_pend_ff && wr_addr_ff == OFF_CTRL) begin
      ctrl_ff <= hwdata[5:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trim_target_ff <= TRIM_RESET;
    end else if (clk_en && wr_pend_ff && wr_addr_ff == OFF_TRIM) begin
      trim_target_ff <= hwdata[TRIM_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_mask_ff <= INT_MASK_RESET;
    end else if (clk_en && wr_pend_ff && wr_addr_ff == OFF_INT_MASK) begin
      int_mask_ff <= hwdata[5:0];
    end
  end

  // Trim walks one code at a time so the oscillator never jumps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trim_applied_ff  <= TRIM_RESET;
      trim_step_cnt_ff <= 8'h00;
    end else if (clk_en) begin
      if (trim_applied_ff == trim_target_ff) begin
        trim_step_cnt_ff <= 8'h00;
      end else if (trim_step_cnt_ff == 8'(TRIM_STEP_CYC - 1)) begin
        trim_step_cnt_ff <= 8'h00;
        if (trim_target_ff > trim_applied_ff) begin
          trim_applied_ff <= trim_applied_ff + 6'sh01;
        end else begin
          trim_applied_ff <= trim_applied_ff - 6'sh01;
        end
      end else begin
        trim_step_cnt_ff <= trim_step_cnt_ff + 8'h01;
      end
    end
  end

  // One trim drives the shared base; the LF source has no trim input
  assign osc_trim_value = trim_applied_ff;

  assign dec     = ioc_decode(ctrl_ff.ifs);
  assign hfmf_en = (dec.src != IOC_SRC_LF)
                && ((config_osc_select == CFG_OSC_INTERNAL) || ctrl_ff.system_clock_source_select[1]);
  assign lf_en   = ((dec.src == IOC_SRC_LF) && ctrl_ff.system_clock_source_select[1])
                || ((dec.src == IOC_SRC_LF) && (config_osc_select == CFG_OSC_INTERNAL))
                || lf_users_active;

  assign high_freq_internal_osc_en   = hfmf_en;
  assign medium_freq_internal_osc_en = hfmf_en;
  assign low_freq_internal_osc_en    = lf_en;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      post_ff <= '{src: IOC_SRC_LF, div_shift: 4'h0};
    end else if (clk_en) begin
      post_ff <= ioc_decode(ctrl_ff.ifs);
    end
  end
  assign postscale_sel = post_ff;

  // Two-flop synchronisers for the analog status levels
  assign raw_in = {lf_running_raw, mf_running_raw, hf_within_stable_raw,
                   hf_within_lock_raw, hf_running_raw};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_RAW; gi++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
        end else if (clk_en) begin
          sync1_ff[gi] <= raw_in[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  assign flags.hf_ready    = sync2_ff[0];
  assign flags.hf_locked   = sync2_ff[1];
  assign flags.hf_stable   = sync2_ff[2];
  assign flags.mf_ready    = sync2_ff[3];
  assign flags.lf_ready    = sync2_ff[4];
  assign flags.ext_running = ext_running_ff;

  // Core runs on the fast start-up oscillator until HF reports ready
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fast_sel_ff <= 1'b1;
    end else if (clk_en) begin
      if (!hfmf_en) begin
        fast_sel_ff <= 1'b1;
      end else if (flags.hf_ready) begin
        fast_sel_ff <= 1'b0;
      end
    end
  end
  assign fast_startup_sel = fast_sel_ff;

  // Clock level edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_prev_ff <= 1'b0;
      ext_prev_ff <= 1'b0;
    end else if (clk_en) begin
      int_prev_ff <= int_osc_level;
      ext_prev_ff <= ext_osc_level;
    end
  end
  assign int_fall = int_prev_ff && !int_osc_level;
  assign ext_fall = ext_prev_ff && !ext_osc_level;
  assign ext_rise = !ext_prev_ff && ext_osc_level;

  // Release of reset counts as a power-on wake
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      por_pending_ff <= 1'b1;
    end else if (clk_en) begin
      por_pending_ff <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ts_state_ff    <= TS_INTERNAL;
      ost_cnt_ff     <= '0;
      ext_running_ff <= 1'b0;
    end else if (clk_en) begin
      if ((wake_start || por_pending_ff) && two_speed_enable) begin
        ts_state_ff    <= TS_OST_COUNT;
        ost_cnt_ff     <= '0;
        ext_running_ff <= 1'b0;
      end else begin
        case (ts_state_ff)
          TS_INTERNAL: begin
            ts_state_ff <= TS_INTERNAL;
          end
          TS_OST_COUNT: begin
            if (ext_rise) begin
              if (ost_cnt_ff == OST_W'(OST_COUNT - 1)) begin
                ts_state_ff <= TS_WAIT_INT_FALL;
              end
              ost_cnt_ff <= ost_cnt_ff + 1'b1;
            end
          end
          TS_WAIT_INT_FALL: begin
            if (int_fall) begin
              ext_running_ff <= 1'b1;
              ts_state_ff    <= TS_WAIT_EXT_FALL;
            end
          end
          TS_WAIT_EXT_FALL: begin
            if (ext_fall) begin
              ts_state_ff <= TS_EXTERNAL;
            end
          end
          TS_EXTERNAL: begin
            ts_state_ff <= TS_EXTERNAL;
          end
          default: begin
            ts_state_ff <= TS_INTERNAL;
          end
        endcase
      end
    end
  end

  assign sys_clk_hold             = (ts_state_ff == TS_WAIT_EXT_FALL);
  assign sys_clk_ext_sel          = (ts_state_ff == TS_EXTERNAL);
  assign osc_startup_timer_active = (ts_state_ff == TS_OST_COUNT);

  // Sticky events on rising flags; a set in the clear cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_prev_ff <= 6'h00;
    end else if (clk_en) begin
      flags_prev_ff <= flags;
    end
  end
  assign flag_rise = flags & ~flags_prev_ff;
  assign w1c_clear = (wr_pend_ff && wr_addr_ff == OFF_INT_STAT) ? hwdata[5:0] : 6'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_stat_ff <= 6'h00;
    end else if (clk_en) begin
      int_stat_ff <= (int_stat_ff & ~w1c_clear) | flag_rise;
    end
  end

  assign irq = |(int_stat_ff & int_mask_ff);

endmodule

/* File: inc/ioc_pkg.sv */
package ioc_pkg;

  localparam int          CLK_PERIOD_NS     = 100;
  localparam int          HADDR_W           = 8;

  // Register byte offsets
  localparam logic [7:0]  OFF_CTRL          = 8'h00;
  localparam logic [7:0]  OFF_TRIM          = 8'h04;
  localparam logic [7:0]  OFF_STATUS        = 8'h08;
  localparam logic [7:0]  OFF_INT_STAT      = 8'h0C;
  localparam logic [7:0]  OFF_INT_MASK      = 8'h10;

  // Control word fields
  localparam int          CTRL_IFS_LSB      = 0;
  localparam int          CTRL_SCS_LSB      = 4;
  localparam logic [3:0]  IFS_RESET         = 4'h0;
  localparam logic [1:0]  SCS_RESET         = 2'h0;
  localparam logic [2:0]  CFG_OSC_INTERNAL  = 3'h4;

  // Trim value
  localparam int          TRIM_W            = 6;
  localparam logic [5:0]  TRIM_RESET        = 6'h00;
  localparam int          TRIM_STEP_NS      = 1000;
  localparam int          TRIM_STEP_CYC     = (TRIM_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Frequency select decode
  localparam logic [3:0]  IFS_LF_CODE       = 4'h0;
  localparam logic [3:0]  IFS_MF_LAST       = 4'h9;
  localparam logic [3:0]  IFS_HF_LAST       = 4'hF;

  // Start-up timer
  localparam int          OST_CYCLES        = 1024;
  localparam int          OST_W             = 11;

  // Status / interrupt bit positions
  localparam int          NUM_FLAGS         = 6;
  localparam int          ST_HF_READY       = 0;
  localparam int          ST_HF_LOCKED      = 1;
  localparam int          ST_HF_STABLE      = 2;
  localparam int          ST_MF_READY       = 3;
  localparam int          ST_LF_READY       = 4;
  localparam int          ST_EXT_RUNNING    = 5;
  localparam logic [5:0]  INT_MASK_RESET    = 6'h00;

  localparam logic [1:0]  HTRANS_NONSEQ     = 2'h2;

  typedef enum logic [1:0] {
    IOC_SRC_LF,
    IOC_SRC_MF,
    IOC_SRC_HF
  } ioc_src_t;

  typedef struct packed {
    logic [1:0] system_clock_source_select;
    logic [3:0] ifs;
  } ioc_ctrl_t;

  typedef struct packed {
    logic       ext_running;
    logic       lf_ready;
    logic       mf_ready;
    logic       hf_stable;
    logic       hf_locked;
    logic       hf_ready;
  } ioc_flags_t;

  typedef struct packed {
    ioc_src_t   src;
    logic [3:0] div_shift;
  } ioc_postscale_t;

endpackage

/* File: verification/internal_osc_clock_control_tb_top.sv */
`timescale 1ns/1ns
module internal_osc_clock_control_tb_top;
  import ioc_pkg::*;
  localparam int OSC_STARTUP_TIMER = 8;
  logic           hclk      = 1'b0;
  logic           hresetn   = 1'b0;
  logic [31:0]    haddr     = 32'h0;
  logic [1:0]     htrans    = 2'h0;
  logic           hwrite    = 1'b0;
  logic [31:0]    hwdata    = 32'h0;
  logic [2:0]     cfg       = 3'h4;
  logic           lf_users  = 1'b0;
  logic           two_speed = 1'b0;
  logic           wake      = 1'b0;
  logic           clk_en    = 1'b1;
  logic [31:0]    hrdata;
  logic           hreadyout;
  logic           irq;
  logic           hresp;
  logic           hf_run, hf_lock, hf_stab, mf_run, lf_run, int_lvl, ext_lvl;
  logic           hf_en, mf_en, lf_en, fast, hold, ext_sel, ost_act;
  logic [5:0]     trim;
  ioc_postscale_t ps;
  logic [31:0]    rd;
  int             num_errors = 0;
  int             cmp_count  = 0;

  always #(CLK_PERIOD_NS / 2) hclk = ~hclk;

  ioc_osc_ctrl #(.OST_COUNT(OSC_STARTUP_TIMER)) dut (
    .hclk, .hresetn, .clk_en, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .irq,
    .config_osc_select(cfg), .lf_users_active(lf_users), .two_speed_enable(two_speed),
    .wake_start(wake), .hf_running_raw(hf_run), .hf_within_lock_raw(hf_lock),
    .hf_within_stable_raw(hf_stab), .mf_running_raw(mf_run), .lf_running_raw(lf_run),
    .int_osc_level(int_lvl), .ext_osc_level(ext_lvl),
    .high_freq_internal_osc_en(hf_en), .medium_freq_internal_osc_en(mf_en),
    .low_freq_internal_osc_en(lf_en), .osc_trim_value(trim), .postscale_sel(ps),
    .fast_startup_sel(fast), .sys_clk_hold(hold), .sys_clk_ext_sel(ext_sel),
    .osc_startup_timer_active(ost_act)
  );

  ioc_osc_model #(.DLY(4)) osc (
    .hclk, .hf_en, .mf_en, .lf_en, .hf_run, .hf_lock, .hf_stab, .mf_run, .lf_run,
    .int_lvl, .ext_lvl
  );

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkb(input string what, input logic exp, input logic got);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask

  task automatic tick(inout int n);
    @(posedge hclk);
    n++;
    if (n > 2000) begin
      num_errors++;
      $display("unexpected wait: expected done seen timeout");
      tally_and_finish();
    end
  endtask

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int n = 0;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do tick(n); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do tick(n); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(what, exp, rd);
  endtask

  // Flags cross a synchroniser, so status is retried a bounded number of times
  task automatic poll(input string what, input logic [7:0] a, input logic [31:0] exp);
    int k = 0;
    do begin
      xfer(a, 1'b0, 32'h0);
      k++;
    end while (rd !== exp && k < 60);
    chk(what, exp, rd);
  endtask

  task automatic t_regs();
    rchk("ctrl_reset", OFF_CTRL, 32'h0);
    rchk("trim_reset", OFF_TRIM, 32'h0);
    rchk("mask_reset", OFF_INT_MASK, 32'h0);
    xfer(OFF_CTRL, 1'b1, 32'hFFFFFFFF);
    rchk("ctrl_rw", OFF_CTRL, 32'h3F);
    xfer(8'h40, 1'b1, 32'hFFFFFFFF);
    rchk("unmapped", 8'h40, 32'h0);
    chkb("hresp_okay", 1'b0, hresp);
    $display("test regs done");
  endtask

  task automatic t_select();
    int n = 0;
    ioc_postscale_t e;
    // {ctrl, lf users, hf expected, lf expected}
    logic [10:0] tbl [6] = '{11'h028, 11'h12A, 11'h0A8, 11'h101, 11'h005, 11'h000};
    for (int i = 0; i < 16; i++) begin
      xfer(OFF_CTRL, 1'b1, 32'(i));
      tick(n);
      tick(n);
      e.src = (i == 0) ? IOC_SRC_LF : (i <= 9) ? IOC_SRC_MF : IOC_SRC_HF;
      e.div_shift = (i == 0) ? 4'h0 : (i <= 9) ? 4'(9 - i) : 4'(15 - i);
      chk("postscale", {26'h0, e}, {26'h0, ps});
      chk("enables", {29'h0, i != 0, i != 0, i == 0}, {29'h0, hf_en, mf_en, lf_en});
    end
    cfg <= 3'h0;
    foreach (tbl[k]) begin
      lf_users <= tbl[k][2];
      xfer(OFF_CTRL, 1'b1, {24'h0, tbl[k][10:3]});
      tick(n);
      chk("enable_table", {30'h0, tbl[k][1:0]}, {30'h0, hf_en, lf_en});
    end
    cfg <= 3'h4;
    $display("test select done");
  endtask

  task automatic t_flags();
    int n = 0;
    xfer(OFF_CTRL, 1'b1, 32'h00);
    poll("status_lf", OFF_STATUS, 32'h10);
    xfer(OFF_INT_STAT, 1'b1, 32'h3F);
    xfer(OFF_INT_MASK, 1'b1, 32'h07);
    xfer(OFF_CTRL, 1'b1, 32'h0F);
    poll("status_hf", OFF_STATUS, 32'h0F);
    rchk("int_stat_hf", OFF_INT_STAT, 32'h0F);
    chkb("irq_on", 1'b1, irq);
    chkb("fast_off", 1'b0, fast);
    xfer(OFF_INT_MASK, 1'b1, 32'h00);
    tick(n);
    chkb("irq_masked", 1'b0, irq);
    xfer(OFF_INT_STAT, 1'b1, 32'h05);
    rchk("int_stat_w1c", OFF_INT_STAT, 32'h0A);
    xfer(OFF_CTRL, 1'b1, 32'h00);
    tick(n);
    tick(n);
    chkb("fast_on", 1'b1, fast);
    poll("status_lf_again", OFF_STATUS, 32'h10);
    rchk("int_stat_lf", OFF_INT_STAT, 32'h1A);
    xfer(OFF_INT_STAT, 1'b1, 32'h3F);
    $display("test flags done");
  endtask

  task automatic t_trim();
    int   n = 0;
    logic lf0;
    lf0 = lf_en;
    xfer(OFF_TRIM, 1'b1, 32'h1F);
    rchk("trim_target", OFF_TRIM, 32'h1F);
    while (trim !== 6'h1F) tick(n);
    xfer(OFF_TRIM, 1'b1, 32'h20);
    while (trim === 6'h1F) tick(n);
    chk("trim_signed_dir", 32'h1E, {26'h0, trim});
    // Frozen block must hold the walk and stall the bus
    clk_en <= 1'b0;
    repeat (30) tick(n);
    chkb("freeze_ready", 1'b0, hreadyout);
    chk("trim_frozen", 32'h1E, {26'h0, trim});
    clk_en <= 1'b1;
    while (trim !== 6'h20) tick(n);
    chkb("lf_en_trim", lf0, lf_en);
    poll("status_trim", OFF_STATUS, 32'h10);
    $display("test trim done");
  endtask

  task automatic t_two_speed();
    int   n = 0;
    int   rises = 0;
    logic saw_hold = 1'b0;
    logic prev;
    two_speed <= 1'b1;
    wake      <= 1'b1;
    tick(n);
    wake <= 1'b0;
    prev = ext_lvl;
    tick(n);
    chkb("ost_active", 1'b1, ost_act);
    while (ext_sel !== 1'b1) begin
      if (ost_act === 1'b1 && ext_lvl === 1'b1 && prev === 1'b0)
        rises++;
      saw_hold |= (hold === 1'b1);
      prev = ext_lvl;
      tick(n);
    end
    chk("ost_rises", OSC_STARTUP_TIMER, rises);
    chkb("hold_seen", 1'b1, saw_hold);
    chkb("hold_released", 1'b0, hold);
    poll("status_ext", OFF_STATUS, 32'h30);
    rchk("int_stat_ext", OFF_INT_STAT, 32'h20);
    xfer(OFF_INT_MASK, 1'b1, 32'h20);
    tick(n);
    chkb("irq_ext", 1'b1, irq);
    // Reset released with two-speed on is a power-on wake
    hresetn <= 1'b0;
    tick(n);
    tick(n);
    chkb("ext_sel_reset", 1'b0, ext_sel);
    hresetn <= 1'b1;
    tick(n);
    chkb("ost_wait_por", 1'b0, ost_act);
    tick(n);
    chkb("ost_por", 1'b1, ost_act);
    $display("test two speed done");
  endtask

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_select();
    t_flags();
    t_trim();
    t_two_speed();
    tally_and_finish();
  end
endmodule

bind ioc_osc_ctrl ioc_osc_ctrl_chk #(.OST_COUNT(OST_COUNT)) chk (
  .hclk, .hresetn, .config_osc_select, .lf_users_active, .two_speed_enable,
  .wake_start, .int_osc_level, .high_freq_internal_osc_en, .medium_freq_internal_osc_en,
  .low_freq_internal_osc_en, .osc_trim_value, .fast_startup_sel, .sys_clk_hold,
  .sys_clk_ext_sel, .osc_startup_timer_active
);

/* File: verification/ioc_osc_ctrl_chk.sv */
`timescale 1ns/1ns
module ioc_osc_ctrl_chk
  import ioc_pkg::*;
#(
  parameter int OST_COUNT = OST_CYCLES
) (
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic [2:0]        config_osc_select,
  input wire logic              lf_users_active,
  input wire logic              two_speed_enable,
  input wire logic              wake_start,
  input wire logic              int_osc_level,
  input wire logic              high_freq_internal_osc_en,
  input wire logic              medium_freq_internal_osc_en,
  input wire logic              low_freq_internal_osc_en,
  input wire logic [TRIM_W-1:0] osc_trim_value,
  input wire logic              fast_startup_sel,
  input wire logic              sys_clk_hold,
  input wire logic              sys_clk_ext_sel,
  input wire logic              osc_startup_timer_active
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  hf_mf_pair_a:
    assert property (high_freq_internal_osc_en == medium_freq_internal_osc_en)
    else $error("hf and mf enables differ");
  src_exclusive_a:
    assert property ((config_osc_select == CFG_OSC_INTERNAL && !lf_users_active)
                     |-> (high_freq_internal_osc_en != low_freq_internal_osc_en))
    else $error("internal config must run exactly one source ladder");
  lf_users_a:
    assert property (lf_users_active |-> low_freq_internal_osc_en)
    else $error("lf source off while users active");
  lf_default_a:
    assert property ((config_osc_select == CFG_OSC_INTERNAL && !high_freq_internal_osc_en)
                     |-> low_freq_internal_osc_en)
    else $error("lf source off with internal config and no hf");
  fast_back_a:
    assert property (!high_freq_internal_osc_en |=> fast_startup_sel)
    else $error("fast oscillator not reselected");
  fast_leave_a:
    assert property ($fell(fast_startup_sel) |-> $past(high_freq_internal_osc_en))
    else $error("fast oscillator left without hf");
  trim_step_a:
    assert property ($changed(osc_trim_value) |->
                     (osc_trim_value == $past(osc_trim_value) + 6'h01 ||
                      osc_trim_value == $past(osc_trim_value) - 6'h01))
    else $error("trim moved by more than one code");
  trim_pace_a:
    assert property ($changed(osc_trim_value) |=> $stable(osc_trim_value)[*8])
    else $error("trim stepped too fast");
  wake_ost_a:
    assert property ((wake_start && two_speed_enable)
                     |=> osc_startup_timer_active && !sys_clk_ext_sel)
    else $error("wake did not start the timer");
  ost_len_a:
    assert property ($rose(osc_startup_timer_active) |-> osc_startup_timer_active[*8])
    else $error("start-up count ended early");
  hold_cause_a:
    assert property ($rose(sys_clk_hold) |-> $past(int_osc_level, 2) && !$past(int_osc_level))
    else $error("hold began without internal falling edge");
  ext_after_hold_a:
    assert property ($rose(sys_clk_ext_sel) |-> $past(sys_clk_hold) && !sys_clk_hold)
    else $error("external select without hold first");
endmodule

/* File: verification/ioc_osc_model.sv */
`timescale 1ns/1ns
module ioc_osc_model #(
  parameter int DLY = 4
) (
  input  wire logic hclk,
  input  wire logic hf_en,
  input  wire logic mf_en,
  input  wire logic lf_en,
  output logic      hf_run,
  output logic      hf_lock,
  output logic      hf_stab,
  output logic      mf_run,
  output logic      lf_run,
  output logic      int_lvl,
  output logic      ext_lvl
);
  int         hf_age = 0;
  logic [7:0] ph     = 8'h00;

  // Flags land mid-cycle: analog side is not timed to hclk
  always @(posedge hclk) begin
    hf_age <= #30 hf_en ? hf_age + 1 : 0;
    ph     <= ph + 8'h01;
  end
  assign hf_run  = hf_age > DLY;
  assign hf_lock = hf_age > 2 * DLY;
  assign hf_stab = hf_age > 3 * DLY;
  // Shared base: mf can only run with the hf ladder
  assign mf_run  = hf_run & mf_en;
  assign lf_run  = lf_en;
  assign int_lvl = ph[2];
  assign ext_lvl = ph[1];
endmodule
